// ### core/dic_top.v
`timescale 1ns/100ps
`default_nettype none
`include "dic_defines.vh"
module dic_top #(
    parameter MS_CYCLES = `DIC_MS_CYCLES
) (
    input  wire        hclk,
    input  wire        hresetn,
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output wire        hreadyout,
    output wire        hresp,
    output wire [31:0] hrdata,
    input  wire        start_fwd_in,
    input  wire        start_rev_in,
    input  wire        ext_fault_close_in,
    input  wire        ext_fault_opening_in,
    input  wire        run_enable_in,
    input  wire        ramp_select_in,
    input  wire        force_terminal_in,
    input  wire        force_keypad_in,
    input  wire        force_fieldbus_in,
    input  wire        reverse_in,
    input  wire        jog_in,
    input  wire        fault_reset_in,
    input  wire        ramp_hold_in,
    input  wire [11:0] free_analog_input,
    input  wire [11:0] second_analog_input,
    output wire        motor_run,
    output wire        motor_reverse,
    output wire        coast_stop,
    output wire        ramp_hold,
    output wire        sleep_stop,
    output wire [1:0]  ctrl_place,
    output wire        fault_active,
    output wire [7:0]  fault_code,
    output wire [15:0] freq_ref,
    output wire [15:0] cur_limit_eff,
    output wire [15:0] dcb_cur_eff,
    output wire [15:0] acc_time,
    output wire [15:0] dec_time,
    output wire [15:0] tq_limit_eff
);
    localparam [31:0] MS_LAST_W = MS_CYCLES - 1;
    localparam [15:0] MS_LAST   = MS_LAST_W[15:0];

    // proportional scale: level 0 gives 0, full level gives cfg
    function [15:0] scale;
        input [15:0] cfg;
        input [11:0] lvl;
        reg   [12:0] x;
        reg   [28:0] p;
        begin
            x     = {1'b0, lvl} + {12'h000, lvl[11]};
            p     = cfg * x;
            scale = p[27:12];
        end
    endfunction
    // ramp divide by factor running 1 at level 0 to 10 at full level
    function [15:0] rdiv;
        input [15:0] t;
        input [11:0] lvl;
        reg   [27:0] num;
        reg   [27:0] den;
        reg   [27:0] quo;
        begin
            num  = t * 28'h0000fff;
            den  = 28'h0000fff + lvl * 28'h0000009;
            quo  = num / den;
            rdiv = quo[15:0];
        end
    endfunction

    wire [`DIC_IN_W-1:0] pin_raw;
    wire [`DIC_IN_W-1:0] pin_s;
    assign pin_raw = {ramp_hold_in, fault_reset_in, jog_in, reverse_in,
                      force_fieldbus_in, force_keypad_in, force_terminal_in,
                      ramp_select_in, run_enable_in, ext_fault_opening_in,
                      ext_fault_close_in, start_rev_in, start_fwd_in};
    dic_sync #(
        .W    (`DIC_IN_W),
        .INIT (`DIC_IN_INIT)
    ) u_sync (
        .clk   (hclk),
        .rst_n (hresetn),
        .d     (pin_raw),
        .q     (pin_s)
    );
    wire s_fwd     = pin_s[0];
    wire s_rev     = pin_s[1];
    wire s_fclose  = pin_s[2];
    wire s_fopen   = pin_s[3];
    wire s_run_en  = pin_s[4];
    wire s_rsel    = pin_s[5];
    wire s_f_term  = pin_s[6];
    wire s_f_kp    = pin_s[7];
    wire s_f_fb    = pin_s[8];
    wire s_revsel  = pin_s[9];
    wire s_jog     = pin_s[10];
    wire s_freset  = pin_s[11];
    wire s_hold    = pin_s[12];
    reg [15:0] ctrl_q;
    reg [3:0]  cmd_q;
    reg [15:0] kp_ref_q;
    reg [15:0] fb_ref_q;
    reg [15:0] jog_ref_q;
    reg [15:0] cur_lim_q;
    reg [15:0] dcb_cur_q;
    reg [15:0] tq_lim_q;
    reg [15:0] acc1_q;
    reg [15:0] dec1_q;
    reg [15:0] acc2_q;
    reg [15:0] dec2_q;
    reg [11:0] slp_lim_q;
    reg [15:0] slp_dly_q;
    reg        wr_pend_q;
    reg [7:0]  wr_addr_q;
    reg [31:0] hrdata_q;
    reg        hreadyout_q;
    reg        hresp_q;
    reg [31:0] rd_val;
    reg        run_q;
    reg        rev_q;
    reg        coast_q;
    reg        hold_q;
    reg        sleep_q;
    reg [1:0]  place_q;
    reg        fault_q;
    reg [7:0]  code_q;
    reg [15:0] ref_q;
    reg [15:0] cur_q;
    reg [15:0] dcb_q;
    reg [15:0] acc_q;
    reg [15:0] dec_q;
    reg [15:0] tq_q;
    reg        freset_prev_q;
    reg [15:0] ms_cnt_q;
    reg [15:0] slp_cnt_q;
    wire       ahb_go  = hsel & htrans[1] & hready;
    wire       in_map  = (haddr[31:8] == 24'h000000);
    wire [31:0] status = {16'h0000, code_q, coast_q, hold_q, sleep_q,
                          fault_q, place_q, rev_q, run_q};
    always @* begin
        rd_val = 32'h00000000;
        if (in_map) begin
            case (haddr[7:0])
                `DIC_A_CTRL:    rd_val = {16'h0000, ctrl_q};
                `DIC_A_CMD:     rd_val = {28'h0000000, cmd_q};
                `DIC_A_KP_REF:  rd_val = {16'h0000, kp_ref_q};
                `DIC_A_FB_REF:  rd_val = {16'h0000, fb_ref_q};
                `DIC_A_JOG_REF: rd_val = {16'h0000, jog_ref_q};
                `DIC_A_CUR_LIM: rd_val = {16'h0000, cur_lim_q};
                `DIC_A_DCB_CUR: rd_val = {16'h0000, dcb_cur_q};
                `DIC_A_TQ_LIM:  rd_val = {16'h0000, tq_lim_q};
                `DIC_A_ACC1:    rd_val = {16'h0000, acc1_q};
                `DIC_A_DEC1:    rd_val = {16'h0000, dec1_q};
                `DIC_A_ACC2:    rd_val = {16'h0000, acc2_q};
                `DIC_A_DEC2:    rd_val = {16'h0000, dec2_q};
                `DIC_A_SLP_LIM: rd_val = {20'h00000, slp_lim_q};
                `DIC_A_SLP_DLY: rd_val = {16'h0000, slp_dly_q};
                `DIC_A_STATUS:  rd_val = status;
                default:        rd_val = 32'h00000000;
            endcase
        end
    end
    // bus slave: zero wait states, read data registered at address phase
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q   <= 1'b0;
            wr_addr_q   <= 8'h00;
            hrdata_q    <= 32'h00000000;
            hreadyout_q <= 1'b1;
            hresp_q     <= 1'b0;
        end else begin
            wr_pend_q <= ahb_go & hwrite & in_map;
            if (ahb_go & hwrite)
                wr_addr_q <= haddr[7:0];
            if (ahb_go & ~hwrite)
                hrdata_q <= rd_val;
        end
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_q    <= `DIC_RST_CTRL;
            cmd_q     <= `DIC_RST_CMD;
            kp_ref_q  <= `DIC_RST_CFG;
            fb_ref_q  <= `DIC_RST_CFG;
            jog_ref_q <= `DIC_RST_CFG;
            cur_lim_q <= `DIC_RST_CFG;
            dcb_cur_q <= `DIC_RST_CFG;
            tq_lim_q  <= `DIC_RST_CFG;
            acc1_q    <= `DIC_RST_CFG;
            dec1_q    <= `DIC_RST_CFG;
            acc2_q    <= `DIC_RST_CFG;
            dec2_q    <= `DIC_RST_CFG;
            slp_lim_q <= `DIC_RST_SLP_LIM;
            slp_dly_q <= `DIC_RST_CFG;
        end else if (wr_pend_q) begin
            case (wr_addr_q)
                `DIC_A_CTRL:    ctrl_q    <= hwdata[15:0];
                `DIC_A_CMD:     cmd_q     <= hwdata[3:0];
                `DIC_A_KP_REF:  kp_ref_q  <= hwdata[15:0];
                `DIC_A_FB_REF:  fb_ref_q  <= hwdata[15:0];
                `DIC_A_JOG_REF: jog_ref_q <= hwdata[15:0];
                `DIC_A_CUR_LIM: cur_lim_q <= hwdata[15:0];
                `DIC_A_DCB_CUR: dcb_cur_q <= hwdata[15:0];
                `DIC_A_TQ_LIM:  tq_lim_q  <= hwdata[15:0];
                `DIC_A_ACC1:    acc1_q    <= hwdata[15:0];
                `DIC_A_DEC1:    dec1_q    <= hwdata[15:0];
                `DIC_A_ACC2:    acc2_q    <= hwdata[15:0];
                `DIC_A_DEC2:    dec2_q    <= hwdata[15:0];
                `DIC_A_SLP_LIM: slp_lim_q <= hwdata[11:0];
                `DIC_A_SLP_DLY: slp_dly_q <= hwdata[15:0];
                default:        ctrl_q    <= ctrl_q;
            endcase
        end
    end
    // control place, start, direction and reference selection
    reg [1:0]  place_v;
    reg        start_d;
    reg        rev_d;
    reg [15:0] ref_d;
    reg [15:0] acc_sel;
    reg [15:0] dec_sel;
    wire [1:0] kp_place = ctrl_q[`DIC_C_KPLACE_HI:`DIC_C_KPLACE_LO];
    wire       fault_set = s_fclose | ~s_fopen;
    wire       freset_rise = s_freset & ~freset_prev_q;
    always @* begin
        place_v = kp_place;
        if (s_f_term) begin
            place_v = `DIC_PLACE_TERM;
        end else if (s_f_kp) begin
            place_v = `DIC_PLACE_KEYPAD;
        end else if (s_f_fb) begin
            place_v = `DIC_PLACE_FBUS;
        end
        start_d = 1'b0;
        rev_d   = 1'b0;
        ref_d   = 16'h0000;
        case (place_v)
            `DIC_PLACE_TERM: begin
                ref_d = {second_analog_input, 4'h0};
                if (ctrl_q[`DIC_C_START2_OTH]) begin
                    start_d = s_fwd;
                    rev_d   = s_revsel;
                end else if (s_fwd) begin
                    start_d = 1'b1;
                    rev_d   = 1'b0;
                end else if (s_rev) begin
                    start_d = 1'b1;
                    rev_d   = 1'b1;
                end
            end
            `DIC_PLACE_KEYPAD: begin
                start_d = cmd_q[`DIC_M_KP_RUN];
                rev_d   = cmd_q[`DIC_M_KP_REV];
                ref_d   = kp_ref_q;
            end
            `DIC_PLACE_FBUS: begin
                start_d = cmd_q[`DIC_M_FB_RUN];
                rev_d   = cmd_q[`DIC_M_FB_REV];
                ref_d   = fb_ref_q;
            end
            default: place_v = `DIC_PLACE_TERM;
        endcase
        if (s_jog)
            ref_d = jog_ref_q;
        acc_sel = s_rsel ? acc2_q : acc1_q;
        dec_sel = s_rsel ? dec2_q : dec1_q;
    end
    // sleep supervision on the second analog input, counted in ms ticks
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ms_cnt_q  <= 16'h0000;
            slp_cnt_q <= 16'h0000;
            sleep_q   <= 1'b0;
        end else if (second_analog_input < slp_lim_q) begin
            if (slp_cnt_q >= slp_dly_q) begin
                sleep_q <= 1'b1;
            end else if (ms_cnt_q == MS_LAST) begin
                ms_cnt_q  <= 16'h0000;
                slp_cnt_q <= slp_cnt_q + 16'h0001;
            end else begin
                ms_cnt_q <= ms_cnt_q + 16'h0001;
            end
        end else begin
            ms_cnt_q  <= 16'h0000;
            slp_cnt_q <= 16'h0000;
            sleep_q   <= 1'b0;
        end
    end
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            freset_prev_q <= 1'b0;
            fault_q       <= 1'b0;
            code_q        <= `DIC_FAULT_NONE;
        end else begin
            freset_prev_q <= s_freset;
            if (fault_set) begin
                fault_q <= 1'b1;
                code_q  <= `DIC_FAULT_EXT;
            end else if (freset_rise) begin
                fault_q <= 1'b0;
                code_q  <= `DIC_FAULT_NONE;
            end
        end
    end
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            run_q   <= 1'b0;
            rev_q   <= 1'b0;
            coast_q <= 1'b0;
            hold_q  <= 1'b0;
            place_q <= `DIC_PLACE_TERM;
            ref_q   <= 16'h0000;
            cur_q   <= 16'h0000;
            dcb_q   <= 16'h0000;
            acc_q   <= 16'h0000;
            dec_q   <= 16'h0000;
            tq_q    <= 16'h0000;
        end else begin
            run_q   <= start_d & s_run_en & ~fault_q & ~fault_set &
                       ~sleep_q;
            rev_q   <= rev_d;
            coast_q <= ~s_run_en & (ctrl_q[`DIC_C_FOLLOWER] |
                                    ctrl_q[`DIC_C_COAST]);
            hold_q  <= s_hold;
            place_q <= place_v;
            if (!s_hold)
                ref_q <= ref_d;
            cur_q <= ctrl_q[`DIC_C_CUR_SCL] ?
                     scale(cur_lim_q, free_analog_input) : cur_lim_q;
            dcb_q <= ctrl_q[`DIC_C_DCB_SCL] ?
                     scale(dcb_cur_q, free_analog_input) : dcb_cur_q;
            acc_q <= ctrl_q[`DIC_C_RAMP_SCL] ?
                     rdiv(acc_sel, free_analog_input) : acc_sel;
            dec_q <= ctrl_q[`DIC_C_RAMP_SCL] ?
                     rdiv(dec_sel, free_analog_input) : dec_sel;
            tq_q  <= ctrl_q[`DIC_C_TQ_SCL] ?
                     scale(tq_lim_q, free_analog_input) : tq_lim_q;
        end
    end
    assign hreadyout     = hreadyout_q;
    assign hresp         = hresp_q;
    assign hrdata        = hrdata_q;
    assign motor_run     = run_q;
    assign motor_reverse = rev_q;
    assign coast_stop    = coast_q;
    assign ramp_hold     = hold_q;
    assign sleep_stop    = sleep_q;
    assign ctrl_place    = place_q;
    assign fault_active  = fault_q;
    assign fault_code    = code_q;
    assign freq_ref      = ref_q;
    assign cur_limit_eff = cur_q;
    assign dcb_cur_eff   = dcb_q;
    assign acc_time      = acc_q;
    assign dec_time      = dec_q;
    assign tq_limit_eff  = tq_q;
endmodule // dic_top
`default_nettype wire

// ### core/dic_defines.vh
`ifndef DIC_DEFINES_VH
`define DIC_DEFINES_VH

`define DIC_CLK_NS        20
`define DIC_MS_NS         1000000
`define DIC_MS_CYCLES     (`DIC_MS_NS / `DIC_CLK_NS)

`define DIC_A_CTRL        8'h00
`define DIC_A_CMD         8'h04
`define DIC_A_KP_REF      8'h08
`define DIC_A_FB_REF      8'h0c
`define DIC_A_JOG_REF     8'h10
`define DIC_A_CUR_LIM     8'h14
`define DIC_A_DCB_CUR     8'h18
`define DIC_A_TQ_LIM      8'h1c
`define DIC_A_ACC1        8'h20
`define DIC_A_DEC1        8'h24
`define DIC_A_ACC2        8'h28
`define DIC_A_DEC2        8'h2c
`define DIC_A_SLP_LIM     8'h30
`define DIC_A_SLP_DLY     8'h34
`define DIC_A_STATUS      8'h38

`define DIC_C_FOLLOWER    0
`define DIC_C_COAST       1
`define DIC_C_START2_OTH  2
`define DIC_C_KPLACE_LO   4
`define DIC_C_KPLACE_HI   5
`define DIC_C_CUR_SCL     8
`define DIC_C_DCB_SCL     9
`define DIC_C_RAMP_SCL    10
`define DIC_C_TQ_SCL      11

`define DIC_M_KP_RUN      0
`define DIC_M_KP_REV      1
`define DIC_M_FB_RUN      2
`define DIC_M_FB_REV      3

`define DIC_S_RUN         0
`define DIC_S_REV         1
`define DIC_S_PLACE_LO    2
`define DIC_S_FAULT       4
`define DIC_S_SLEEP       5
`define DIC_S_HOLD        6
`define DIC_S_COAST       7
`define DIC_S_CODE_LO     8

`define DIC_RST_CTRL      16'h0000
`define DIC_RST_CFG       16'h0000
`define DIC_RST_CMD       4'h0
`define DIC_RST_SLP_LIM   12'h000

`define DIC_PLACE_TERM    2'h0
`define DIC_PLACE_KEYPAD  2'h1
`define DIC_PLACE_FBUS    2'h2

`define DIC_FAULT_NONE    8'h00
`define DIC_FAULT_EXT     8'h33

`define DIC_IN_W          13
`define DIC_IN_INIT       13'h0008
`endif

// ### core/dic_sync.v
`timescale 1ns/100ps
`default_nettype none
module dic_sync #(
    parameter W    = 1,
    parameter INIT = 0
) (
    input  wire         clk,
    input  wire         rst_n,
    input  wire [W-1:0] d,
    output wire [W-1:0] q
);
    reg [W-1:0] meta_q;
    reg [W-1:0] sync_q;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= INIT;
            sync_q <= INIT;
        end else begin
            meta_q <= d;
            sync_q <= meta_q;
        end
    end

    assign q = sync_q;
endmodule // dic_sync
`default_nettype wire

// ### test/dic_contacts.sv
`timescale 1ns/100ps
`default_nettype none
module dic_contacts (
    input  wire        clk,
    input  wire [12:0] want,
    output var logic [12:0] pins
);
    // contacts settle one edge after a command, opening fault contact starts closed
    initial pins = 13'h0008;
    always @(posedge clk) pins <= want;
endmodule // dic_contacts
`default_nettype wire

// ### test/dic_properties.sv
`timescale 1ns/100ps
`default_nettype none
`include "dic_defines.vh"
module dic_checker (
    input wire        hclk,
    input wire        hresetn,
    input wire        ext_fault_close_in,
    input wire        ext_fault_opening_in,
    input wire        run_enable_in,
    input wire        force_terminal_in,
    input wire        force_keypad_in,
    input wire        force_fieldbus_in,
    input wire        fault_reset_in,
    input wire        motor_run,
    input wire        ramp_hold,
    input wire [1:0]  ctrl_place,
    input wire        fault_active,
    input wire [7:0]  fault_code,
    input wire [15:0] freq_ref
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // pin history older than reset is not judged
    reg  [1:0] up_q;
    wire       ok = (up_q == 2'h3);
    always @(posedge hclk or negedge hresetn)
        if (!hresetn)
            up_q <= 2'h0;
        else if (!ok)
            up_q <= up_q + 2'h1;
    place_term_a: assert property (ok && $past(force_terminal_in, 3)
        |-> ctrl_place == `DIC_PLACE_TERM) else $error("place not terminal");
    place_kp_a: assert property (ok && !$past(force_terminal_in, 3)
        && $past(force_keypad_in, 3) |-> ctrl_place == `DIC_PLACE_KEYPAD)
        else $error("place not keypad");
    place_fb_a: assert property (ok && !$past(force_terminal_in, 3)
        && !$past(force_keypad_in, 3) && $past(force_fieldbus_in, 3)
        |-> ctrl_place == `DIC_PLACE_FBUS) else $error("place not fieldbus");
    fault_close_a: assert property (ok && $past(ext_fault_close_in, 3)
        |-> fault_active && fault_code == `DIC_FAULT_EXT)
        else $error("closing fault missed");
    fault_open_a: assert property (ok && !$past(ext_fault_opening_in, 3)
        |-> fault_active && fault_code == `DIC_FAULT_EXT)
        else $error("opening fault missed");
    fault_stop_a: assert property (fault_active && $past(fault_active)
        |-> !motor_run) else $error("runs under fault");
    run_block_a: assert property (ok && !$past(run_enable_in, 3)
        |-> !motor_run) else $error("runs without enable");
    reset_edge_a: assert property (ok && $fell(fault_active)
        |-> $past(fault_reset_in, 3) && !$past(fault_reset_in, 4))
        else $error("fault cleared without edge");
    hold_freeze_a: assert property (ramp_hold && $past(ramp_hold)
        |-> $stable(freq_ref)) else $error("reference moved in hold");
endmodule // dic_checker
bind dic_top dic_checker u_checker (
    .hclk, .hresetn, .ext_fault_close_in, .ext_fault_opening_in,
    .run_enable_in, .force_terminal_in, .force_keypad_in,
    .force_fieldbus_in, .fault_reset_in, .motor_run, .ramp_hold,
    .ctrl_place, .fault_active, .fault_code, .freq_ref
);
`default_nettype wire

// ### test/tb_dic_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "dic_defines.vh"
module tb_dic_top;
    logic        hclk = 1'h0, hresetn = 1'h0, hsel = 1'h0, hwrite = 1'h0;
    logic [1:0]  htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, rq;
    logic [11:0] free_analog_input = 12'h0, second_analog_input = 12'h0;
    logic [12:0] want = 13'h0008;
    logic [32:0] rows [10];
    wire  [12:0] p;
    wire  [31:0] hrdata;
    wire  [15:0] freq_ref, cur_limit_eff, dcb_cur_eff, acc_time, dec_time;
    wire  [15:0] tq_limit_eff;
    wire  [7:0]  fault_code;
    wire  [1:0]  ctrl_place;
    wire         hreadyout, hresp, motor_run, motor_reverse, coast_stop;
    wire         ramp_hold, sleep_stop, fault_active;
    wire  [3:0]  st = {motor_run, motor_reverse, ctrl_place};
    wire  [9:0]  ft = {motor_run, fault_active, fault_code};
    integer      fails = 0, n_tests = 0, i;

    dic_top #(.MS_CYCLES(4)) DUT (
        .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
        .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata,
        .start_fwd_in(p[0]), .start_rev_in(p[1]), .ext_fault_close_in(p[2]),
        .ext_fault_opening_in(p[3]), .run_enable_in(p[4]),
        .ramp_select_in(p[5]), .force_terminal_in(p[6]),
        .force_keypad_in(p[7]), .force_fieldbus_in(p[8]), .reverse_in(p[9]),
        .jog_in(p[10]), .fault_reset_in(p[11]), .ramp_hold_in(p[12]),
        .free_analog_input, .second_analog_input, .motor_run, .motor_reverse,
        .coast_stop, .ramp_hold, .sleep_stop, .ctrl_place, .fault_active,
        .fault_code, .freq_ref, .cur_limit_eff, .dcb_cur_eff, .acc_time,
        .dec_time, .tq_limit_eff
    );
    dic_contacts u_contacts (.clk(hclk), .want(want), .pins(p));

    always #10 hclk = ~hclk;

    task chk(input string nm, input logic [47:0] e, g);
        n_tests = n_tests + 1;
        if (g !== e) begin
            fails = fails + 1;
            $display("[ERR] %0s exp %h got %h", nm, e, g);
        end
    endtask
    task xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'h1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {24'h0, a};
        do @(posedge hclk); while (hreadyout !== 1'h1);
        hsel <= 1'h0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'h1);
        rq = hrdata;
    endtask
    task w(input logic [7:0] a, input logic [31:0] d);
        xfer(1'h1, a, d);
    endtask
    task pins(input logic [12:0] v);
        want <= v;
        repeat (6) @(posedge hclk);
        #1;
    endtask
    task stop_test;
        $display("tests %0d fails %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial begin
        #80000;
        fails = fails + 1;
        stop_test;
    end

    initial begin
        rows[0] = {16'h0000, 13'h0019, 4'h8};
        rows[1] = {16'h0000, 13'h001a, 4'hc};
        rows[2] = {16'h0000, 13'h0009, 4'h0};
        rows[3] = {16'h0004, 13'h0219, 4'hc};
        rows[4] = {16'h0004, 13'h001a, 4'h0};
        rows[5] = {16'h0010, 13'h0059, 4'h8};
        rows[6] = {16'h0010, 13'h0018, 4'h1};
        rows[7] = {16'h0020, 13'h0198, 4'h1};
        rows[8] = {16'h0000, 13'h0118, 4'h2};
        rows[9] = {16'h0010, 13'h01d8, 4'h0};
        repeat (20) @(posedge hclk);
        hresetn <= 1'h1;
        #1;
        chk("reset", 48'h1, {hresp, st, fault_active, freq_ref, hreadyout});
        w(8'h3c, 32'hffffffff);
        xfer(1'h0, 8'h3c, 32'h0);
        chk("unmapped", 48'h0, rq);
        for (i = 0; i < 10; i = i + 1) begin
            w(`DIC_A_CTRL, {16'h0, rows[i][32:17]});
            pins(rows[i][16:4]);
            chk("run rev place", rows[i][3:0], st);
        end
        w(`DIC_A_KP_REF, 32'h1234);
        w(`DIC_A_FB_REF, 32'h0777);
        w(`DIC_A_CMD, 32'h7);
        pins(13'h0018);
        chk("keypad", 48'hd1234, {st, freq_ref});
        xfer(1'h0, `DIC_A_STATUS, 32'h0);
        chk("status", 48'h7, rq);
        xfer(1'h0, `DIC_A_KP_REF, 32'h0);
        chk("kp ref", 48'h1234, rq);
        w(`DIC_A_CTRL, 32'h20);
        pins(13'h0018);
        chk("fieldbus", 48'ha0777, {st, freq_ref});
        @(posedge hclk) second_analog_input <= 12'h123;
        w(`DIC_A_JOG_REF, 32'h0abc);
        w(`DIC_A_CTRL, 32'h0);
        pins(13'h0019);
        chk("ref", 48'h1230, freq_ref);
        pins(13'h0419);
        chk("jog", 48'h0abc, freq_ref);
        pins(13'h0019);
        pins(13'h1019);
        @(posedge hclk) second_analog_input <= 12'h456;
        pins(13'h1019);
        chk("hold", 48'h11230, {ramp_hold, freq_ref});
        pins(13'h0019);
        chk("release", 48'h04560, {ramp_hold, freq_ref});
        w(`DIC_A_ACC1, 32'h64);
        w(`DIC_A_DEC1, 32'h6e);
        w(`DIC_A_ACC2, 32'hc8);
        w(`DIC_A_DEC2, 32'hdc);
        w(`DIC_A_CUR_LIM, 32'h3e8);
        w(`DIC_A_DCB_CUR, 32'h320);
        w(`DIC_A_TQ_LIM, 32'h258);
        pins(13'h0019);
        chk("set 1", 48'h0064006e, {acc_time, dec_time});
        pins(13'h0039);
        chk("set 2", 48'h00c800dc, {acc_time, dec_time});
        w(`DIC_A_CTRL, 32'hf00);
        @(posedge hclk) free_analog_input <= 12'hfff;
        pins(13'h0039);
        chk("ramp max", 48'h00140016, {acc_time, dec_time});
        chk("max", 48'h03e803200258, {cur_limit_eff, dcb_cur_eff,
            tq_limit_eff});
        @(posedge hclk) free_analog_input <= 12'h800;
        pins(13'h0039);
        chk("half", 48'h01f40190012c, {cur_limit_eff, dcb_cur_eff,
            tq_limit_eff});
        @(posedge hclk) free_analog_input <= 12'h000;
        pins(13'h0039);
        chk("zero", 48'h0, {cur_limit_eff, dcb_cur_eff, tq_limit_eff});
        chk("ramp zero", 48'h00c800dc, {acc_time, dec_time});
        w(`DIC_A_CTRL, 32'h0);
        pins(13'h001d);
        chk("close", 48'h133, ft);
        pins(13'h081d);
        chk("reset held", 48'h133, ft);
        pins(13'h0819);
        chk("level", 48'h133, ft);
        pins(13'h0019);
        pins(13'h0819);
        chk("edge", 48'h200, ft);
        pins(13'h0011);
        chk("open", 48'h133, ft);
        pins(13'h0019);
        pins(13'h0819);
        chk("open clear", 48'h200, ft);
        for (i = 0; i < 4; i = i + 1) begin
            w(`DIC_A_CTRL, i);
            pins(13'h0009);
            chk("coast", i != 0, {motor_run, coast_stop});
        end
        pins(13'h0019);
        chk("enabled", 48'h1, {coast_stop, motor_run});
        w(`DIC_A_CTRL, 32'h0);
        w(`DIC_A_SLP_LIM, 32'h100);
        w(`DIC_A_SLP_DLY, 32'h2);
        pins(13'h0019);
        @(posedge hclk) second_analog_input <= 12'h080;
        repeat (4) @(posedge hclk);
        #1;
        chk("sleep early", 48'h1, {sleep_stop, motor_run});
        repeat (12) @(posedge hclk);
        #1;
        chk("sleep", 48'h2, {sleep_stop, motor_run});
        @(posedge hclk) second_analog_input <= 12'h200;
        pins(13'h0019);
        chk("wake", 48'h1, {sleep_stop, motor_run});
        @(posedge hclk) hresetn <= 1'h0;
        @(posedge hclk) hresetn <= 1'h1;
        #1;
        chk("reset run", 48'h1, {hresp, st, fault_active, freq_ref,
            hreadyout});
        xfer(1'h0, `DIC_A_SLP_LIM, 32'h0);
        chk("cfg clear", 48'h0, rq);
        pins(13'h0019);
        chk("rerun", 48'h8, st);
        stop_test;
    end
endmodule // tb_dic_top
`default_nettype wire
